// ==== acm_clock_config_monitor.sv ====
`timescale 1ns/1ps
// ****************************************
// audio serial port clock configuration
// ****************************************
module acm_clock_config_monitor #(
   parameter int BCLK_HALF = 4 // system clocks per bit clock half period
) (
   input wire logic clock_in, // system clock
   input wire logic reset_n_in, // async reset, active low
   input wire logic [7:0] reg_addr_in, // register offset
   input wire logic [7:0] reg_wdata_in, // write data
   input wire logic reg_write_in, // write strobe
   input wire logic reg_read_in, // read strobe
   output logic [7:0] reg_rdata_out, // read data, next cycle
   input wire logic clock_master_select_in, // 1 device drives clocks
   input wire logic auto_config_in, // 1 automatic configuration
   input wire logic auto_pll_off_in, // pll off in auto mode
   input wire logic rate_family_select_in, // 0 48k family, 1 44.1k
   input wire logic [2:0] ref_freq_code_in, // master clock frequency code
   input wire logic bit_clock_in, // bit clock pin level
   output logic bit_clock_out, // bit clock drive
   output logic bit_clock_oe_n_out, // low while driving
   input wire logic frame_sync_in, // frame sync pin level
   output logic frame_sync_out, // frame sync drive
   output logic frame_sync_oe_n_out, // low while driving
   output logic [3:0] eff_rate_code_out, // rate code in use
   output logic [3:0] eff_ratio_code_out, // bits per frame code in use
   output logic rate_family_out, // family in use
   output logic root_is_mclk_out, // audio root from master clock
   output logic pll_enable_out, // pll running
   output logic ref_by_ratio_out, // master clock given as frame multiple
   output logic [2:0] ref_freq_code_out, // absolute frequency code
   output logic [11:0] mclk_ratio_out // master clock per frame
);
   // divider range check at elaboration
   if (BCLK_HALF < 1 || BCLK_HALF > 255)
   begin : gen_half_check
      $error("BCLK_HALF out of range");
   end

   typedef struct packed {
      logic [7:0] rate_ratio;
      logic [7:0] clock_source_ctrl;
      logic [7:0] pdm_clk;
      logic [7:0] rdata;
      logic [7:0] div;
      logic bclk;
      logic fs;
      logic [11:0] bit_cnt;
      logic oe_n;
      logic [3:0] eff_rate;
      logic [3:0] eff_ratio;
      logic family;
      logic root_mclk;
      logic pll_on;
      logic by_ratio;
      logic [2:0] freq_code;
      logic [11:0] mclk_ratio;
   } acm_top_t;

   acm_top_t state;
   acm_top_t next_state;
   logic [1:0] rst_sync;
   logic rst_n;
   logic [3:0] det_rate;
   logic [3:0] det_ratio;
   logic slave_auto;
   logic [11:0] frame_len;
   logic gen_edge;

   // ****************************************
   // reset release
   // ****************************************
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   // monitor of pin activity
   acm_frame_meter meter (
      .clock_in(clock_in),
      .rst_n_in(rst_n),
      .bit_clock_pin_in(bit_clock_in),
      .frame_sync_pin_in(frame_sync_in),
      .detected_rate_code_out(det_rate),
      .detected_ratio_code_out(det_ratio)
   );

   assign slave_auto = ~clock_master_select_in & auto_config_in;
   // bits per frame from programmed code
   assign frame_len = acm_pkg::ratio_value(state.rate_ratio[acm_pkg::RATIO_LSB +: 4]);

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      next_state = state;
      gen_edge = 1'b0;
      // register writes, full byte stored
      if (reg_write_in)
      begin
         unique case (reg_addr_in)
            acm_pkg::OFS_RATE_RATIO: next_state.rate_ratio = reg_wdata_in;
            acm_pkg::OFS_CLOCK_SOURCE_CTRL: next_state.clock_source_ctrl = reg_wdata_in;
            acm_pkg::OFS_PDM_CLK: next_state.pdm_clk = reg_wdata_in;
            default: next_state.rate_ratio = state.rate_ratio;
         endcase
      end
      // register reads, unmapped read zero
      if (reg_read_in)
      begin
         unique case (reg_addr_in)
            acm_pkg::OFS_RATE_RATIO: next_state.rdata = state.rate_ratio;
            acm_pkg::OFS_MON_STATUS: next_state.rdata = {det_rate, det_ratio};
            acm_pkg::OFS_CLOCK_SOURCE_CTRL: next_state.rdata = state.clock_source_ctrl;
            acm_pkg::OFS_PDM_CLK: next_state.rdata = state.pdm_clk;
            default: next_state.rdata = 8'h00;
         endcase
      end
      // drive clocks only in master mode
      next_state.oe_n = ~clock_master_select_in;
      if (clock_master_select_in && frame_len != 12'h000)
      begin
         if (state.div == 8'(BCLK_HALF - 1))
         begin
            next_state.div = 8'h00;
            next_state.bclk = ~state.bclk;
            // frame sync on rising edge when inverted
            gen_edge = state.clock_source_ctrl[acm_pkg::INV_EDGE_BIT] ? ~state.bclk : state.bclk;
         end
         else
            next_state.div = state.div + 8'h01;
         if (gen_edge)
         begin
            next_state.fs = (state.bit_cnt == frame_len - 12'h001);
            next_state.bit_cnt = next_state.fs ? 12'h000 : state.bit_cnt + 12'h001;
         end
      end
      else
      begin
         next_state.div = 8'h00;
         next_state.bclk = 1'b0;
         next_state.fs = 1'b0;
         next_state.bit_cnt = 12'h000;
      end
      if (slave_auto)
      begin
         next_state.eff_rate = det_rate;
         next_state.eff_ratio = det_ratio;
      end
      else
      begin
         next_state.eff_rate = state.rate_ratio[acm_pkg::RATE_LSB +: 4];
         next_state.eff_ratio = state.rate_ratio[acm_pkg::RATIO_LSB +: 4];
      end
      next_state.family = clock_master_select_in & rate_family_select_in;
      // pll off only under automatic configuration
      next_state.pll_on = ~(auto_config_in & auto_pll_off_in);
      // root source with pll off in slave auto
      next_state.root_mclk = slave_auto & auto_pll_off_in & state.clock_source_ctrl[acm_pkg::ROOT_SEL_BIT];
      next_state.by_ratio = auto_config_in & state.clock_source_ctrl[acm_pkg::FREQ_MODE_BIT];
      next_state.freq_code = ref_freq_code_in;
      next_state.mclk_ratio = acm_pkg::mclk_ratio_value(state.clock_source_ctrl[acm_pkg::MCLK_RATIO_LSB +: 3]);
   end

   // state register
   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= '0;
         state.rate_ratio <= acm_pkg::RST_RATE_RATIO;
         state.clock_source_ctrl <= acm_pkg::RST_CLOCK_SOURCE_CTRL;
         state.pdm_clk <= acm_pkg::RST_PDM_CLK;
         state.oe_n <= 1'b1;
         state.eff_rate <= acm_pkg::RST_RATE_RATIO[7:4];
         state.eff_ratio <= acm_pkg::RST_RATE_RATIO[3:0];
         state.pll_on <= 1'b1;
         state.mclk_ratio <= 12'd384;
      end
      else
         state <= next_state;
   end

   // outputs from flops
   assign reg_rdata_out = state.rdata;
   assign bit_clock_out = state.bclk;
   assign bit_clock_oe_n_out = state.oe_n;
   assign frame_sync_out = state.fs;
   assign frame_sync_oe_n_out = state.oe_n;
   assign eff_rate_code_out = state.eff_rate;
   assign eff_ratio_code_out = state.eff_ratio;
   assign rate_family_out = state.family;
   assign root_is_mclk_out = state.root_mclk;
   assign pll_enable_out = state.pll_on;
   assign ref_by_ratio_out = state.by_ratio;
   assign ref_freq_code_out = state.freq_code;
   assign mclk_ratio_out = state.mclk_ratio;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n);

   master_drive_a: assert property (clock_master_select_in [*2] |-> !bit_clock_oe_n_out && !frame_sync_oe_n_out)
      else $error("clocks not driven in master mode");
   slave_auto_a: assert property (slave_auto [*2] |-> eff_rate_code_out == $past(det_rate))
      else $error("slave auto not using detected rate");
   prog_rate_a: assert property (!slave_auto ##1 !slave_auto |-> eff_rate_code_out == $past(state.rate_ratio[7:4]))
      else $error("programmed rate not applied");
   fs_edge_a: assert property ($changed(frame_sync_out) && $past(clock_master_select_in && frame_len != 12'h000)
      |-> bit_clock_out == $past(state.clock_source_ctrl[1]))
      else $error("frame sync on wrong bit clock edge");
   root_src_a: assert property (root_is_mclk_out |-> $past(slave_auto && auto_pll_off_in))
      else $error("root source outside pll-off slave auto");
   pll_off_a: assert property (auto_config_in && auto_pll_off_in |=> !pll_enable_out)
      else $error("pll still on");
   master_c: cover property (clock_master_select_in && $rose(frame_sync_out));
   slave_auto_c: cover property (slave_auto && det_rate != 4'hf);
endmodule : acm_clock_config_monitor

// ==== acm_pkg.sv ====
// Summary of operation
// - sample rate code 0..8 selects 8k..768k or 44.1k family; 9..15 reserved
// - bits per frame code 0..12 selects 16..2048 bit clocks; 13..15 reserved
// - slave with automatic configuration ignores programmed rate and ratio codes
// - detected rate is read-only, same encoding, 15 means invalid
// - detected ratio is read-only, 16..2048, 15 means invalid
// - monitor status resets to all ones, both fields invalid
// - slave auto with PLL off: 0 bit clock root, 1 master clock root
// - frequency mode 0 uses absolute code, 1 uses frame-sync multiple; ref_by_ratio_out set only under automatic configuration
// - master clock to frame ratio code 0..7 gives 64..2304
// - invert bit moves frame sync generation to other bit-clock edge only
// - master select 0 receives clocks, 1 drives bit clock and frame sync
// - rate family bit picks 48k multiples at 0, 44.1k at 1; rate_family_out held at 0 in slave mode
// - PLL-off bit disables PLL under automatic configuration
// - 3-bit code gives master clock frequency 12 to 24.576 MHz
package acm_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] OFS_RATE_RATIO = 8'h14;
   localparam logic [7:0] OFS_MON_STATUS = 8'h15;
   localparam logic [7:0] OFS_CLOCK_SOURCE_CTRL = 8'h16;
   localparam logic [7:0] OFS_PDM_CLK = 8'h1f;
   localparam logic [7:0] RST_RATE_RATIO = 8'h48;
   localparam logic [7:0] RST_MON_STATUS = 8'hff;
   localparam logic [7:0] RST_CLOCK_SOURCE_CTRL = 8'h10;
   localparam logic [7:0] RST_PDM_CLK = 8'h40;
   // field positions
   localparam int RATE_LSB = 4;
   localparam int RATIO_LSB = 0;
   localparam int ROOT_SEL_BIT = 7;
   localparam int FREQ_MODE_BIT = 6;
   localparam int MCLK_RATIO_LSB = 3;
   localparam int INV_EDGE_BIT = 1;
   localparam logic [3:0] CODE_INVALID = 4'hf;
   localparam logic [3:0] RATE_CODE_MAX = 4'h8;
   localparam logic [3:0] RATIO_CODE_MAX = 4'hc;
   // timing
   localparam int CLK_HZ = 200000000;
   localparam int TOL_SHIFT = 5; // tolerance of one part in 32

   // bit clocks per frame for a ratio code
   function automatic logic [11:0] ratio_value(input logic [3:0] code);
      logic [11:0] v;
      v = 12'h000;
      unique case (code)
         4'h0: v = 12'd16;
         4'h1: v = 12'd24;
         4'h2: v = 12'd32;
         4'h3: v = 12'd48;
         4'h4: v = 12'd64;
         4'h5: v = 12'd96;
         4'h6: v = 12'd128;
         4'h7: v = 12'd192;
         4'h8: v = 12'd256;
         4'h9: v = 12'd384;
         4'ha: v = 12'd512;
         4'hb: v = 12'd1024;
         4'hc: v = 12'd2048;
         default: v = 12'h000;
      endcase
      return v;
   endfunction : ratio_value

   // master clock to frame sync ratio
   function automatic logic [11:0] mclk_ratio_value(input logic [2:0] code);
      logic [11:0] v;
      v = 12'h000;
      unique case (code)
         3'h0: v = 12'd64;
         3'h1: v = 12'd256;
         3'h2: v = 12'd384;
         3'h3: v = 12'd512;
         3'h4: v = 12'd768;
         3'h5: v = 12'd1024;
         3'h6: v = 12'd1536;
         3'h7: v = 12'd2304;
      endcase
      return v;
   endfunction : mclk_ratio_value

   // measured bit count to ratio code, invalid if no match
   function automatic logic [3:0] ratio_encode(input logic [11:0] count);
      logic [3:0] c;
      c = CODE_INVALID;
      for (int i = 0; i <= 12; i++)
      begin
         if (count == ratio_value(i[3:0]))
            c = i[3:0];
      end
      return c;
   endfunction : ratio_encode

   // frame period in clocks to rate code, either family accepted
   function automatic logic [3:0] rate_encode(input logic [15:0] period);
      int base48;
      int base44;
      int nom;
      logic [3:0] c;
      base48 = 8000;
      base44 = 7350;
      c = CODE_INVALID;
      for (int i = 0; i <= 8; i++)
      begin
         // codes 4 and up: 6, 12, 24, 48, 96 times the base rate
         nom = CLK_HZ / (base48 * ((i < 4) ? (i + 1) : (6 << (i - 4))));
         if ((int'(period) >= nom - (nom >> TOL_SHIFT)) && (int'(period) <= nom + (nom >> TOL_SHIFT)))
            c = i[3:0];
         nom = CLK_HZ / (base44 * ((i < 4) ? (i + 1) : (6 << (i - 4))));
         if ((int'(period) >= nom - (nom >> TOL_SHIFT)) && (int'(period) <= nom + (nom >> TOL_SHIFT)))
            c = i[3:0];
      end
      return c;
   endfunction : rate_encode
endpackage : acm_pkg

// ==== acm_frame_meter.sv ====
`timescale 1ns/1ps
// ****************************************
// frame clock monitor
// ****************************************
module acm_frame_meter (
   input wire logic clock_in, // system clock
   input wire logic rst_n_in, // synchronised reset, active low
   input wire logic bit_clock_pin_in, // bit clock pin level
   input wire logic frame_sync_pin_in, // frame sync pin level
   output logic [3:0] detected_rate_code_out, // detected rate status
   output logic [3:0] detected_ratio_code_out // detected ratio status
);
   typedef struct packed {
      logic [2:0] bsync; // bit clock sync chain, [0] first stage
      logic [2:0] frame_sync; // frame sync sync chain
      logic started;
      logic [11:0] bit_cnt;
      logic [15:0] clk_cnt;
      logic [3:0] last_rate;
      logic [3:0] last_ratio;
      logic [3:0] rate_code;
      logic [3:0] ratio_code;
   } acm_meter_t;

   acm_meter_t state;
   acm_meter_t next_state;
   logic b_rise;
   logic f_rise;
   logic [3:0] m_rate;
   logic [3:0] m_ratio;

   // edges from the second and third stages only
   assign b_rise = state.bsync[1] & ~state.bsync[2];
   assign f_rise = state.frame_sync[1] & ~state.frame_sync[2];
   assign m_rate = acm_pkg::rate_encode(state.clk_cnt);
   assign m_ratio = acm_pkg::ratio_encode(state.bit_cnt);

   // measurement and commit
   always_comb
   begin
      next_state = state;
      next_state.bsync = {state.bsync[1:0], bit_clock_pin_in};
      next_state.frame_sync = {state.frame_sync[1:0], frame_sync_pin_in};
      if (state.clk_cnt != 16'hffff)
         next_state.clk_cnt = state.clk_cnt + 16'h0001;
      if (b_rise && state.bit_cnt != 12'hfff)
         next_state.bit_cnt = state.bit_cnt + 12'h001;
      if (f_rise)
      begin
         next_state.clk_cnt = 16'h0001;
         next_state.bit_cnt = b_rise ? 12'h001 : 12'h000;
         next_state.started = 1'b1;
         if (state.started)
         begin
            next_state.last_rate = m_rate;
            next_state.last_ratio = m_ratio;
            if (m_rate == state.last_rate && m_ratio == state.last_ratio)
            begin
               next_state.rate_code = m_rate;
               next_state.ratio_code = m_ratio;
            end
         end
      end
      else if (state.clk_cnt == 16'hffff)
      begin
         next_state.started = 1'b0;
         next_state.rate_code = acm_pkg::CODE_INVALID;
         next_state.ratio_code = acm_pkg::CODE_INVALID;
         next_state.last_rate = acm_pkg::CODE_INVALID;
         next_state.last_ratio = acm_pkg::CODE_INVALID;
      end
   end

   // state register
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state <= '0;
         state.rate_code <= acm_pkg::RST_MON_STATUS[7:4];
         state.ratio_code <= acm_pkg::RST_MON_STATUS[3:0];
         state.last_rate <= acm_pkg::CODE_INVALID;
         state.last_ratio <= acm_pkg::CODE_INVALID;
      end
      else
         state <= next_state;
   end

   assign detected_rate_code_out = state.rate_code;
   assign detected_ratio_code_out = state.ratio_code;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   timeout_invalid_a: assert property (state.clk_cnt == 16'hffff && !f_rise |=> state.rate_code == 4'hf)
      else $error("status not invalid after timeout");
   ratio_legal_a: assert property (state.ratio_code <= acm_pkg::RATIO_CODE_MAX || state.ratio_code == 4'hf)
      else $error("reserved ratio status");
   rate_legal_a: assert property (state.rate_code <= acm_pkg::RATE_CODE_MAX || state.rate_code == 4'hf)
      else $error("reserved rate status");
   stable_commit_a: assert property ($changed(state.rate_code) && state.rate_code != 4'hf |-> $past(state.last_rate) == state.rate_code)
      else $error("rate status updated without stable measurement");
   valid_rate_c: cover property ($rose(state.rate_code == 4'h4));
endmodule : acm_frame_meter

// ==== acm_host_model.sv ====
`timescale 1ns/1ps
// ****************************************
// host side clock source for slave mode
// ****************************************
module acm_host_model (
   input wire logic clock_in, // system clock
   input wire logic enable_in, // 1 sends frames
   input wire logic [7:0] half_in, // clocks per bit clock half period
   input wire logic [11:0] bits_in, // bit clocks per frame
   output logic bit_clock_out = 1'b0, // bit clock to device
   output logic frame_sync_out = 1'b0 // frame sync to device
);
   logic [7:0] hcnt = 8'h00;
   logic [11:0] bcnt = 12'h000;
   // clocks stand low outside frames; frame sync moves on falling bit clock
   always_ff @(posedge clock_in)
   begin
      if (!enable_in)
      begin
         hcnt <= 8'h00;
         bcnt <= 12'h000;
         bit_clock_out <= 1'b0;
         frame_sync_out <= 1'b0;
      end
      else if (hcnt == half_in - 8'h01)
      begin
         hcnt <= 8'h00;
         bit_clock_out <= ~bit_clock_out;
         if (bit_clock_out)
         begin
            bcnt <= (bcnt == bits_in - 12'h001) ? 12'h000 : bcnt + 12'h001;
            frame_sync_out <= (bcnt == bits_in - 12'h001);
         end
      end
      else
         hcnt <= hcnt + 8'h01;
   end
endmodule : acm_host_model

// ==== tb_asi_clock_config_monitor.sv ====
`timescale 1ns/1ps
module tb_asi_clock_config_monitor;
   logic clock_in = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic ms = 1'b0;
   logic auto_cfg = 1'b0;
   logic pll_off = 1'b0;
   logic fam = 1'b0;
   logic [2:0] rfc = 3'h0;
   logic host_en = 1'b0;
   logic [7:0] host_half = 8'h21;
   logic [11:0] host_bits = 12'h020;
   logic [7:0] rdata;
   logic bclk_o, bclk_oe_n, fs_o, fs_oe_n, host_bclk, host_fs, bclk_w, fs_w;
   logic [3:0] eff_rate, eff_ratio;
   logic fam_o, root_o, pll_en, by_ratio;
   logic [2:0] rfc_o;
   logic [11:0] mclk_o;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [7:0] v, d14, d16;
   logic [3:0] er;
   localparam logic [11:0] MCLK_TAB [8] = '{12'h040, 12'h100, 12'h180, 12'h200, 12'h300, 12'h400, 12'h600, 12'h900};
   localparam logic [7:0] RST_ADR [5] = '{8'h14, 8'h15, 8'h16, 8'h1f, 8'h17};
   localparam logic [7:0] RST_VAL [5] = '{8'h48, 8'hff, 8'h10, 8'h40, 8'h00};
   localparam logic [7:0] MON_HALF [3] = '{8'h21, 8'h23, 8'h34};
   localparam logic [11:0] MON_BITS [3] = '{12'h020, 12'h040, 12'h028};
   localparam logic [7:0] MON_EXP [3] = '{8'h52, 8'h44, 8'h4f};

   // clock and shared pin levels
   always #2.5 clock_in = ~clock_in;
   assign bclk_w = !bclk_oe_n ? bclk_o : host_bclk;
   assign fs_w = !fs_oe_n ? fs_o : host_fs;

   acm_clock_config_monitor #(.BCLK_HALF(1)) DUT (.clock_in(clock_in), .reset_n_in(rst_n), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_write_in(wr_en), .reg_read_in(rd_en), .reg_rdata_out(rdata),
      .clock_master_select_in(ms), .auto_config_in(auto_cfg), .auto_pll_off_in(pll_off),
      .rate_family_select_in(fam), .ref_freq_code_in(rfc), .bit_clock_in(bclk_w), .bit_clock_out(bclk_o),
      .bit_clock_oe_n_out(bclk_oe_n), .frame_sync_in(fs_w), .frame_sync_out(fs_o), .frame_sync_oe_n_out(fs_oe_n),
      .eff_rate_code_out(eff_rate), .eff_ratio_code_out(eff_ratio), .rate_family_out(fam_o),
      .root_is_mclk_out(root_o), .pll_enable_out(pll_en), .ref_by_ratio_out(by_ratio),
      .ref_freq_code_out(rfc_o), .mclk_ratio_out(mclk_o));

   acm_host_model host (.clock_in(clock_in), .enable_in(host_en), .half_in(host_half), .bits_in(host_bits),
      .bit_clock_out(host_bclk), .frame_sync_out(host_fs));

   // ****************************************
   // tasks
   // ****************************************
   task automatic results;
      if (error_cnt == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock_in);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_in);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock_in);
      rd_en <= 1'b0;
      @(negedge clock_in);
      d = rdata;
   endtask : rd

   // hang guard
   always @(posedge clock_in)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         error_cnt++;
         results();
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      void'($urandom(32'h463ee8d9));
      repeat (12) @(posedge clock_in);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock_in);
      for (int i = 0; i < 5; i++)
      begin
         rd(RST_ADR[i], v);
         chk(12'(v), 12'(RST_VAL[i]));
      end
      wr(8'h15, 8'($urandom));
      rd(8'h15, v);
      chk(12'(v), 12'h0ff);
      for (int i = 0; i < 16; i++)
      begin
         @(posedge clock_in);
         {ms, auto_cfg, pll_off, fam, rfc} <= 7'($urandom);
         d14 = {4'($urandom_range(8)), 4'($urandom_range(12))};
         d16 = 8'($urandom) & 8'hfa;
         repeat (3) @(posedge clock_in);
         wr(8'h14, d14);
         wr(8'h16, d16);
         wr(8'h1f, d14);
         repeat (3) @(posedge clock_in);
         rd(8'h14, v);
         chk(12'(v), 12'(d14));
         rd(8'h16, v);
         chk(12'(v), 12'(d16));
         rd(8'h1f, v);
         chk(12'(v), 12'(d14));
         chk(mclk_o, MCLK_TAB[d16[5:3]]);
         chk(12'(root_o), 12'(!ms & auto_cfg & pll_off & d16[7]));
         if (ms)
         begin
            chk(12'({eff_rate, eff_ratio}), 12'(d14));
            chk(12'(fam_o), 12'(fam));
         end
         else if (auto_cfg)
         begin
            rd(8'h15, v);
            chk(12'({eff_rate, eff_ratio}), 12'(v));
         end
         if (auto_cfg)
         begin
            chk(12'(pll_en), 12'(!pll_off));
            chk(12'(by_ratio), 12'(d16[6]));
            if (!d16[6])
               chk(12'(rfc_o), 12'(rfc));
         end
      end
      @(posedge clock_in);
      ms <= 1'b1;
      auto_cfg <= 1'b0;
      wr(8'h14, 8'h40);
      for (int inv = 0; inv < 2; inv++)
      begin
         wr(8'h16, {5'h02, 1'b0, inv[0], 1'b0});
         repeat (40) @(posedge clock_in);
         chk(12'({bclk_oe_n, fs_oe_n}), 12'h000);
         er = 4'(fs_o);
         for (int c = 1, last = 0; c < 100; c++)
         begin
            @(negedge clock_in);
            if (fs_o !== er[0])
            begin
               chk(12'(bclk_o), 12'(inv));
               if (fs_o === 1'b1 && last != 0)
                  chk(12'(c - last), 12'd32);
               if (fs_o === 1'b1)
                  last = c;
               else if (last != 0)
                  chk(12'(c - last), 12'd2);
            end
            er = 4'(fs_o);
         end
      end
      // reserved ratio code stops the bit clock
      wr(8'h14, 8'h4d);
      repeat (10) @(posedge clock_in);
      for (int c = 0; c < 8; c++)
      begin
         @(negedge clock_in);
         chk(12'(bclk_o), 12'h000);
      end
      @(posedge clock_in);
      ms <= 1'b0;
      auto_cfg <= 1'b1;
      for (int r = 0; r < 3; r++)
      begin
         @(posedge clock_in);
         host_en <= 1'b0;
         repeat (5) @(posedge clock_in);
         host_half <= MON_HALF[r];
         host_bits <= MON_BITS[r];
         host_en <= 1'b1;
         rd(8'h15, v);
         for (int k = 0; k < 6000 && v !== MON_EXP[r]; k++)
            rd(8'h15, v);
         chk(12'(v), 12'(MON_EXP[r]));
         chk(12'({eff_rate, eff_ratio}), 12'(MON_EXP[r]));
         chk(12'({bclk_oe_n, fs_oe_n}), 12'h003);
      end
      results();
   end
endmodule : tb_asi_clock_config_monitor
